//--- uocs_pkg.sv
`default_nettype none
package uocs_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_LINE_STATUS = 12'h000;
   localparam logic [11:0] ADDR_CONTROL     = 12'h004;
   localparam logic [11:0] ADDR_FRAME_HIGH  = 12'h008;
   localparam logic [11:0] ADDR_TOKEN       = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h010;
   localparam logic [11:0] ADDR_IRQ_MASK    = 12'h014;
   localparam logic [11:0] ADDR_MODE        = 12'h018;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CABLE_BIT      = 7;
   localparam int STABLE_BIT     = 5;
   localparam int SESS_BIT       = 3;
   localparam int SESS_END_BIT   = 2;
   localparam int VBUS_BIT       = 0;
   localparam int JLINE_BIT      = 7;
   localparam int SE0_BIT        = 6;
   localparam int PKT_BIT        = 5;
   localparam int BUSRST_BIT     = 4;
   localparam int HOST_CAPABILITY_ENABLE_BIT     = 3;
   localparam int RESUME_BIT     = 2;
   localparam int PPCLR_BIT      = 1;
   localparam int ENABLE_BIT     = 0;
   // interrupt status bits
   localparam int IRQ_CABLE      = 0;
   localparam int IRQ_STABLE     = 1;
   localparam int IRQ_SESS       = 2;
   localparam int IRQ_TOKDONE    = 3;
   localparam int IRQ_SETUP      = 4;

   // ------------------------------------------------------------
   // reset values and token codes
   // ------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] TOKEN_RESET   = 8'h00;
   localparam logic [4:0] IRQ_RESET     = 5'h00;
   localparam logic [3:0] PID_SETUP     = 4'hd;
   localparam logic [3:0] PID_IN        = 4'h9;
   localparam logic [3:0] PID_OUT       = 4'h1;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ         = 20_000_000;
   localparam int STABLE_TIME_US = 1000;
   localparam int STABLE_CYCLES  = (CLK_HZ / 1_000_000) * STABLE_TIME_US;
   localparam int EOP_TIME_NS    = 1330;
   localparam int EOP_CYCLES     = (EOP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [1:0] {TOK_IDLE, TOK_RUN} uocs_tok_e;
endpackage : uocs_pkg
`default_nettype wire

//--- uocs_top.sv
// What this block does
// - cable type flag reads 1 for no cable or B cable, 0 for A cable.
// - line-stable flag set only after SE0 and J unchanged for 1 ms.
// - session-valid flag follows VBUS above session threshold.
// - B-device session-end flag set while VBUS below session level.
// - A-device VBUS-valid flag set while VBUS above session level.
// - control bit 7 is live read-only J-state flag.
// - control bit 6 is live read-only SE0 flag.
// - device mode bit 5 disables packets; hardware sets it on SETUP token.
// - host mode bit 5 reads token busy while a token executes.
// - host mode bus reset bit drives USB reset while set.
// - host enable bit turns host on; every toggle resets host logic.
// - resume signalling while bit set; host appends low-speed EOP on clear.
// - upper three frame bits latched on each received SOF token.
// - token type codes SETUP 1101, IN 1001, OUT 0001 only.
// - bits 31 to 8 and unused low bits read zero.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uocs_top
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // line and cable inputs from pins
   input  wire logic        cable_id_i,
   input  wire logic        line_j_i,
   input  wire logic        line_se0_i,
   input  wire logic        vbus_sess_i,
   // protocol engine events
   input  wire logic        sof_rx_i,
   input  wire logic [2:0]  sof_frame_high_i,
   input  wire logic        setup_rx_i,
   input  wire logic        token_done_i,
   // protocol engine controls
   output logic             token_start_o,
   output logic [3:0]       token_pid_o,
   output logic [3:0]       token_ep_o,
   output logic             bus_reset_drive_o,
   output logic             resume_drive_o,
   output logic             eop_drive_o,
   output logic             host_logic_reset_o,
   output logic             host_mode_o,
   output logic             packet_processing_disable_o,
   output logic             module_enable_o,
   output logic             pingpong_pointer_clear_o,
   // interrupt
   output logic             irq_o
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   // stage one is read only by stage two
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end
      else
      begin
         sync1_reg <= {cable_id_i, line_j_i, line_se0_i, vbus_sess_i};
         sync2_reg <= sync1_reg;
      end
   end
   wire cable_type_flag = sync2_reg[3];
   wire live_j_line_flag = sync2_reg[2];
   wire se0_line_flag = sync2_reg[1];
   wire vbus_above = sync2_reg[0];

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire acc      = psel_i && penable_i;
   wire wr       = acc && pwrite_i;
   wire hit_stat = (paddr_i == uocs_pkg::ADDR_LINE_STATUS);
   wire hit_ctl  = (paddr_i == uocs_pkg::ADDR_CONTROL);
   wire hit_frm  = (paddr_i == uocs_pkg::ADDR_FRAME_HIGH);
   wire hit_tok  = (paddr_i == uocs_pkg::ADDR_TOKEN);
   wire hit_ist  = (paddr_i == uocs_pkg::ADDR_IRQ_STATUS);
   wire hit_msk  = (paddr_i == uocs_pkg::ADDR_IRQ_MASK);
   wire hit_mode = (paddr_i == uocs_pkg::ADDR_MODE);
   wire hit_any  = hit_stat || hit_ctl || hit_frm || hit_tok || hit_ist || hit_msk || hit_mode;
   wire wr_ctl   = wr && hit_ctl;
   wire wr_tok   = wr && hit_tok;

   // ------------------------------------------------------------
   // line stability timer
   // ------------------------------------------------------------
   logic [1:0]  line_prev_reg;
   logic [14:0] stable_cnt_reg;
   logic        line_stable_reg;
   wire line_changed = (line_prev_reg != {live_j_line_flag, se0_line_flag});
   // any change restarts the 1 ms window
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         line_prev_reg   <= 2'h0;
         stable_cnt_reg  <= 15'h0;
         line_stable_reg <= 1'b0;
      end
      else
      begin
         line_prev_reg <= {live_j_line_flag, se0_line_flag};
         if (line_changed)
         begin
            stable_cnt_reg  <= 15'h0;
            line_stable_reg <= 1'b0;
         end
         else if (stable_cnt_reg == 15'(uocs_pkg::STABLE_CYCLES - 1))
            line_stable_reg <= 1'b1;
         else
            stable_cnt_reg <= stable_cnt_reg + 15'h1;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic       pkt_disable_reg;
   logic       bus_reset_reg;
   logic       host_en_reg;
   logic       resume_reg;
   logic       ppclr_reg;
   logic       enable_reg;
   logic       host_reset_reg;
   logic [2:0] frame_high_reg;
   wire host_toggle = wr_ctl && (pwdata_i[uocs_pkg::HOST_CAPABILITY_ENABLE_BIT] != host_en_reg);
   // setup arrival wins over a software clear in the same cycle
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pkt_disable_reg <= 1'b0;
         bus_reset_reg   <= 1'b0;
         host_en_reg     <= 1'b0;
         resume_reg      <= 1'b0;
         ppclr_reg       <= 1'b0;
         enable_reg      <= 1'b0;
         host_reset_reg  <= 1'b0;
         frame_high_reg  <= 3'h0;
      end
      else
      begin
         if (wr_ctl)
         begin
            pkt_disable_reg <= pwdata_i[uocs_pkg::PKT_BIT];
            bus_reset_reg   <= pwdata_i[uocs_pkg::BUSRST_BIT];
            host_en_reg     <= pwdata_i[uocs_pkg::HOST_CAPABILITY_ENABLE_BIT];
            resume_reg      <= pwdata_i[uocs_pkg::RESUME_BIT];
            ppclr_reg       <= pwdata_i[uocs_pkg::PPCLR_BIT];
            enable_reg      <= pwdata_i[uocs_pkg::ENABLE_BIT];
         end
         if (setup_rx_i && !host_en_reg)
            pkt_disable_reg <= 1'b1;
         host_reset_reg <= host_toggle;
         if (sof_rx_i)
            frame_high_reg <= sof_frame_high_i;
      end
   end

   // ------------------------------------------------------------
   // resume end-of-packet tail
   // ------------------------------------------------------------
   // wide enough for the whole low-speed eop time at this clock
   logic [4:0] eop_cnt_reg;
   wire resume_fall = wr_ctl && resume_reg && !pwdata_i[uocs_pkg::RESUME_BIT];
   // low-speed eop only follows resume when acting as host
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         eop_cnt_reg <= 5'h00;
      else if (resume_fall && host_en_reg)
         eop_cnt_reg <= 5'(uocs_pkg::EOP_CYCLES);
      else if (eop_cnt_reg != 5'h00)
         eop_cnt_reg <= eop_cnt_reg - 5'h01;
   end

   // ------------------------------------------------------------
   // token engine
   // ------------------------------------------------------------
   uocs_pkg::uocs_tok_e tok_state_reg;
   logic [7:0] token_reg;
   logic       tok_start_reg;
   wire pid_ok = (pwdata_i[7:4] == uocs_pkg::PID_SETUP) || (pwdata_i[7:4] == uocs_pkg::PID_IN)
                 || (pwdata_i[7:4] == uocs_pkg::PID_OUT);
   wire tok_launch = wr_tok && host_en_reg && pid_ok && (tok_state_reg == uocs_pkg::TOK_IDLE);
   // a host enable toggle aborts any running token
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tok_state_reg <= uocs_pkg::TOK_IDLE;
         token_reg     <= uocs_pkg::TOKEN_RESET;
         tok_start_reg <= 1'b0;
      end
      else
      begin
         if (wr_tok)
            token_reg <= pwdata_i[7:0];
         tok_start_reg <= tok_launch;
         if (host_toggle)
            tok_state_reg <= uocs_pkg::TOK_IDLE;
         else
            case (tok_state_reg)
               uocs_pkg::TOK_IDLE: if (tok_launch) tok_state_reg <= uocs_pkg::TOK_RUN;
               uocs_pkg::TOK_RUN:  if (token_done_i) tok_state_reg <= uocs_pkg::TOK_IDLE;
               default:            tok_state_reg <= uocs_pkg::TOK_IDLE;
            endcase
      end
   end
   wire tok_busy = (tok_state_reg == uocs_pkg::TOK_RUN);

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   logic [4:0] irq_stat_reg;
   logic [4:0] irq_mask_reg;
   logic [2:0] flags_prev_reg;
   wire [2:0] flags_now = {vbus_above, line_stable_reg, cable_type_flag};
   wire [4:0] irq_event = {setup_rx_i && !host_en_reg, tok_busy && token_done_i,
                           flags_now ^ flags_prev_reg};
   wire [4:0] irq_clr = (wr && hit_ist) ? pwdata_i[4:0] : 5'h00;
   // set beats clear when both land together
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         irq_stat_reg   <= uocs_pkg::IRQ_RESET;
         irq_mask_reg   <= uocs_pkg::IRQ_RESET;
         flags_prev_reg <= 3'h0;
      end
      else
      begin
         irq_stat_reg   <= (irq_stat_reg & ~irq_clr) | irq_event;
         flags_prev_reg <= flags_now;
         if (wr && hit_msk)
            irq_mask_reg <= pwdata_i[4:0];
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   wire [7:0] stat_byte = {cable_type_flag, 1'b0, line_stable_reg, 1'b0,
                           vbus_above, !vbus_above, 1'b0, vbus_above};
   wire bit5 = host_en_reg ? tok_busy : pkt_disable_reg;
   wire [7:0] ctl_byte = {live_j_line_flag, se0_line_flag, bit5, bus_reset_reg,
                          host_en_reg, resume_reg, ppclr_reg, enable_reg};
   // upper bits always read zero
   wire [7:0] rd_byte = hit_stat ? stat_byte :
                        hit_ctl  ? ctl_byte :
                        hit_frm  ? {5'h00, frame_high_reg} :
                        hit_tok  ? token_reg :
                        hit_ist  ? {3'h0, irq_stat_reg} :
                        hit_msk  ? {3'h0, irq_mask_reg} :
                        hit_mode ? {7'h00, host_en_reg} : 8'h00;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         prdata_o <= 32'h0;
      else if (psel_i && !penable_i && !pwrite_i)
         prdata_o <= {24'h000000, rd_byte};
   end
   assign pready_o  = 1'b1;
   assign pslverr_o = acc && !hit_any;

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign token_start_o               = tok_start_reg;
   assign token_pid_o                 = token_reg[7:4];
   assign token_ep_o                  = token_reg[3:0];
   assign bus_reset_drive_o           = bus_reset_reg && host_en_reg;
   assign resume_drive_o              = resume_reg;
   assign eop_drive_o                 = (eop_cnt_reg != 5'h00);
   assign host_logic_reset_o          = host_reset_reg;
   assign host_mode_o                 = host_en_reg;
   assign packet_processing_disable_o = pkt_disable_reg && !host_en_reg;
   assign module_enable_o             = enable_reg;
   assign pingpong_pointer_clear_o    = ppclr_reg;
   assign irq_o                       = |(irq_stat_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_setup_sets_pkt: assert property (setup_rx_i && !host_en_reg |=> pkt_disable_reg)
      else $error("setup did not disable packets");
   a_busy_after_launch: assert property (tok_launch && !host_toggle |=> tok_busy && token_start_o)
      else $error("token launch did not set busy");
   a_busy_read: assert property (host_en_reg |-> ctl_byte[5] == tok_busy)
      else $error("bit five not busy in host mode");
   a_toggle_reset: assert property (host_toggle |=> host_logic_reset_o && !tok_busy)
      else $error("host toggle did not reset");
   a_frame_latch: assert property (sof_rx_i |=> frame_high_reg == $past(sof_frame_high_i))
      else $error("frame high not latched");
   a_stable_clear: assert property (line_changed |=> !line_stable_reg)
      else $error("line stable kept after change");
   a_sess_pair: assert property (stat_byte[2] != stat_byte[3])
      else $error("session end not opposite session valid");
   a_vbus_pair: assert property (stat_byte[0] == stat_byte[3])
      else $error("vbus valid mismatch");
   a_upper_zero: assert property (prdata_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_eop_tail: assert property (resume_fall && host_en_reg |=> eop_drive_o [*4])
      else $error("eop tail missing");
   c_token_run: cover property (tok_launch ##[1:20] token_done_i);
   c_setup: cover property (setup_rx_i && !host_en_reg);
   c_irq: cover property (irq_o);
endmodule : uocs_top
`default_nettype wire

//--- uocs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module uocs_far_model
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // requests from the bench and the block
   input  wire logic       token_start_i,
   input  wire logic       slow_i,
   input  wire logic       sof_req_i,
   input  wire logic [2:0] sof_val_i,
   input  wire logic       setup_req_i,
   // events towards the block
   output logic            sof_rx_o,
   output logic [2:0]      sof_frame_high_o,
   output logic            setup_rx_o,
   output logic            token_done_o
);
   // ---------------------------------------------
   // far side of the cable
   // ---------------------------------------------
   int         wait_cnt;
   logic [2:0] last_frame;

   // frame bits mean nothing outside the pulse, so they never show a stale value there
   assign sof_frame_high_o = sof_rx_o ? last_frame : ~last_frame;

   // one transaction takes a short or a long bus time before the handshake ends
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wait_cnt     <= 0;
         token_done_o <= 1'b0;
         sof_rx_o     <= 1'b0;
         setup_rx_o   <= 1'b0;
         last_frame   <= 3'h0;
      end
      else
      begin
         token_done_o <= (wait_cnt == 1);
         if (token_start_i)
            wait_cnt <= slow_i ? 40 : 3;
         else if (wait_cnt != 0)
            wait_cnt <= wait_cnt - 1;
         sof_rx_o     <= sof_req_i;
         setup_rx_o   <= setup_req_i;
         if (sof_req_i)
            last_frame <= sof_val_i;
      end
   end
endmodule : uocs_far_model
`default_nettype wire

//--- uocs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uocs_top_tb;
   logic        clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd, w;
   logic        cable, jl, se0, vbus, sofr, setr, done, start, slow, sofq, setq;
   logic        busrst, resume, eop, hlr, hmode, pktd, men, ppc, irq;
   logic [2:0]  fh, sofv;
   logic [3:0]  pid, ep;
   logic [7:0]  tq[$];
   logic [3:0]  pids[3] = '{uocs_pkg::PID_SETUP, uocs_pkg::PID_IN, uocs_pkg::PID_OUT};
   int          n_fail, n_checks, hl_cnt, eop_cnt, st_cnt, i, h;

   uocs_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cable_id_i(cable), .line_j_i(jl), .line_se0_i(se0), .vbus_sess_i(vbus),
      .sof_rx_i(sofr), .sof_frame_high_i(fh), .setup_rx_i(setr), .token_done_i(done),
      .token_start_o(start), .token_pid_o(pid), .token_ep_o(ep), .bus_reset_drive_o(busrst),
      .resume_drive_o(resume), .eop_drive_o(eop), .host_logic_reset_o(hlr), .host_mode_o(hmode),
      .packet_processing_disable_o(pktd), .module_enable_o(men), .pingpong_pointer_clear_o(ppc),
      .irq_o(irq));
   uocs_far_model FAR (.clk_i(clk_i), .reset_n_i(reset_n_i), .token_start_i(start), .slow_i(slow),
      .sof_req_i(sofq), .sof_val_i(sofv), .setup_req_i(setq), .sof_rx_o(sofr),
      .sof_frame_high_o(fh), .setup_rx_o(setr), .token_done_o(done));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task end_of_test;
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // one apb transfer; outputs are looked at on the falling edge once it is over
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      k = 0;
      @(posedge clk_i);
      while (pready !== 1'b1 && k < 50)
      begin
         k++;
         @(posedge clk_i);
      end
      if (k >= 50)
      begin
         n_fail++;
         end_of_test();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_i);
   endtask : apb

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk

   // software polls the busy flag, bounded, before any further token
   task wait_idle;
      int k;
      k = 0;
      apb(1'b0, uocs_pkg::ADDR_CONTROL, 32'h0);
      while (rd[uocs_pkg::PKT_BIT] !== 1'b0 && k < 100)
      begin
         k++;
         apb(1'b0, uocs_pkg::ADDR_CONTROL, 32'h0);
      end
      if (k >= 100)
      begin
         n_fail++;
         end_of_test();
      end
   endtask : wait_idle

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [31:0] exp_sts(input logic st);
      return {24'h0, cable, 1'b0, st, 1'b0, vbus, ~vbus, 1'b0, vbus};
   endfunction : exp_sts

   // pulse counters, and every launched token against the queue of expected ones
   always @(posedge clk_i)
   begin
      if (reset_n_i)
      begin
         hl_cnt  += hlr;
         eop_cnt += eop;
         if (start === 1'b1)
         begin
            st_cnt++;
            chk({pid, ep}, (tq.size() != 0) ? tq.pop_front() : 8'hxx);
         end
      end
   end

   // ---------------------------------------------
   // stimulus
   // ---------------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {jl, se0, vbus, slow, sofq, setq, sofv} = '0;
      cable     = 1'b1;
      rnd       = 32'hb97cfa5d;
      reset_n_i = 1'b0;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd_chk(uocs_pkg::ADDR_CONTROL, 32'h0);
      rd_chk(uocs_pkg::ADDR_TOKEN, 32'h0);
      rd_chk(uocs_pkg::ADDR_FRAME_HIGH, 32'h0);
      rd_chk(uocs_pkg::ADDR_LINE_STATUS, exp_sts(0));
      apb(1'b0, 12'h01c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      for (i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         @(posedge clk_i);
         {cable, jl, se0, vbus} <= rnd[3:0];
         repeat (5) @(posedge clk_i);
         rd_chk(uocs_pkg::ADDR_LINE_STATUS, exp_sts(0));
         rd_chk(uocs_pkg::ADDR_CONTROL, {jl, se0, 6'h0});
      end
      repeat (uocs_pkg::STABLE_CYCLES + 20) @(posedge clk_i);
      rd_chk(uocs_pkg::ADDR_LINE_STATUS, exp_sts(1));
      @(posedge clk_i);
      jl <= ~jl;
      repeat (5) @(posedge clk_i);
      rd_chk(uocs_pkg::ADDR_LINE_STATUS, exp_sts(0));
      w = lfsr(rnd) & 32'hffff_fff7;
      apb(1'b1, uocs_pkg::ADDR_CONTROL, w);
      rd_chk(uocs_pkg::ADDR_CONTROL, {jl, se0, w[5:0]});
      chk({pktd, busrst, resume, ppc, men}, {w[5], 1'b0, w[2:0]});
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h0);
      h = hl_cnt;
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h08);
      // the reset pulse follows the write by one edge
      @(negedge clk_i);
      chk({31'(hl_cnt - h), hmode}, {31'h1, 1'b1});
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h18);
      chk(busrst, 1'b1);
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h08);
      chk(busrst, 1'b0);
      // resume held only briefly: the block just follows the bit, the long hold is software's job
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h0c);
      chk(resume, 1'b1);
      i = eop_cnt;
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h08);
      repeat (uocs_pkg::EOP_CYCLES + 5) @(posedge clk_i);
      chk({resume, 31'(eop_cnt - i)}, {1'b0, 31'(uocs_pkg::EOP_CYCLES)});
      apb(1'b1, uocs_pkg::ADDR_IRQ_STATUS, 32'h1f);
      apb(1'b1, uocs_pkg::ADDR_IRQ_MASK, 32'h0);
      for (i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         slow <= (i != 1);
         wait_idle();
         tq.push_back({pids[i], rnd[3:0]});
         apb(1'b1, uocs_pkg::ADDR_TOKEN, {rnd[31:8], pids[i], rnd[3:0]});
         if (i != 1)
            rd_chk(uocs_pkg::ADDR_CONTROL, {jl, se0, 6'h28});
      end
      wait_idle();
      h = st_cnt;
      tq.push_back({uocs_pkg::PID_IN, 4'h2});
      apb(1'b1, uocs_pkg::ADDR_TOKEN, {24'h0, uocs_pkg::PID_IN, 4'h2});
      apb(1'b1, uocs_pkg::ADDR_TOKEN, {24'h0, uocs_pkg::PID_OUT, 4'h3});
      wait_idle();
      apb(1'b1, uocs_pkg::ADDR_TOKEN, 32'h52);
      repeat (5) @(posedge clk_i);
      chk({8'(st_cnt - h), 24'(tq.size())}, {8'h1, 24'h0});
      rd_chk(uocs_pkg::ADDR_IRQ_STATUS, 32'h08);
      chk(irq, 1'b0);
      apb(1'b1, uocs_pkg::ADDR_IRQ_MASK, 32'h08);
      chk(irq, 1'b1);
      apb(1'b1, uocs_pkg::ADDR_IRQ_STATUS, 32'h08);
      chk(irq, 1'b0);
      for (i = 0; i < 2; i++)
      begin
         rnd = lfsr(rnd);
         @(posedge clk_i);
         sofq <= 1'b1;
         sofv <= rnd[2:0];
         @(posedge clk_i);
         sofq <= 1'b0;
         repeat (3) @(posedge clk_i);
         rd_chk(uocs_pkg::ADDR_FRAME_HIGH, {29'h0, sofv});
      end
      h = hl_cnt;
      apb(1'b1, uocs_pkg::ADDR_CONTROL, 32'h0);
      @(negedge clk_i);
      chk({31'(hl_cnt - h), pktd}, {31'h1, 1'b0});
      @(posedge clk_i);
      setq <= 1'b1;
      @(posedge clk_i);
      setq <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(pktd, 1'b1);
      rd_chk(uocs_pkg::ADDR_CONTROL, {jl, se0, 6'h20});
      rd_chk(uocs_pkg::ADDR_IRQ_STATUS, 32'h10);
      end_of_test();
   end
endmodule : uocs_top_tb
`default_nettype wire
